// *** src/mle_unit.sv ***
// Purpose: Sequencer for multiple, stack and exclusive load/store operations.
// Assumes: Register reads are combinational through the read port; bus answers later.
// Notes: Condition flags are not touched here; the unit has no flag output. RULE8
`timescale 1ns/1ps
`default_nettype none
module mle_unit (
    input wire logic I_SYS_CLK,                        // Core clock
    input wire logic I_RESETN,                         // Async reset, active low
    input wire logic I_CMD_VALID,                      // Command offered
    input wire mle_pkg::mle_cmd_type I_CMD,            // Decoded command
    output logic O_CMD_READY,                          // Idle, command accepted
    output logic [3:0] O_RD_IDX,                       // Register read index
    input wire logic [31:0] I_RD_DATA,                 // Register read data
    input wire logic [31:0] I_BASE_DATA,               // Value of base register
    output mle_pkg::mle_bus_type O_BUS,                // Memory request
    input wire logic I_BUS_ACK,                        // Memory done
    input wire logic [31:0] I_BUS_RDATA,               // Memory read data
    input wire logic I_SNOOP_VALID,                    // Other master wrote memory
    input wire logic [31:0] I_SNOOP_ADDR,              // Address of that write
    output mle_pkg::mle_wr_type O_REG_WR,              // Register write pulse
    output logic O_BRANCH,                             // Branch pulse
    output logic [31:0] O_BRANCH_ADDR,                 // Branch target
    output logic O_DONE                                // Command finished pulse
);
    typedef enum logic [1:0] {S_IDLE, S_REQ, S_WAIT, S_WB} mle_state_type;
    mle_state_type state_ff, nxt_state;
    logic [15:0] list_ff, nxt_list;
    logic [31:0] addr_ff, nxt_addr;
    logic [31:0] wbv_ff, nxt_wbv;
    logic [3:0] base_ff, nxt_base;
    logic [3:0] cur_ff, nxt_cur;
    logic [3:0] st_ff, nxt_st;
    logic [1:0] size_ff, nxt_size;
    logic up_ff, nxt_up, load_ff, nxt_load, wb_ff, nxt_wb, excl_ff, nxt_excl;
    logic mon_ff, nxt_mon;
    logic [31:0] mon_addr_ff, nxt_mon_addr;
    logic [1:0] mon_size_ff, nxt_mon_size;
    mle_pkg::mle_bus_type bus_ff, nxt_bus;
    mle_pkg::mle_wr_type wr_ff, nxt_wr;
    logic br_ff, nxt_br, done_ff, nxt_done, rdy_ff;
    logic [31:0] bra_ff, nxt_bra;
    logic [3:0] lo_idx, hi_idx, pick;
    logic [4:0] cnt;
    logic [31:0] span;
    logic [31:0] size_mask;

    // Lowest and highest set bits in the remaining list; count of set bits in the incoming command list
    always_comb begin
        lo_idx = '0;
        hi_idx = '0;
        cnt = '0;
        for (int i = mle_pkg::NREG - 1; i >= 0; i--) begin
            if (list_ff[i]) begin
                lo_idx = 4'(i);
            end
        end
        for (int i = 0; i < mle_pkg::NREG; i++) begin
            if (list_ff[i]) begin
                hi_idx = 4'(i);
            end
            cnt = cnt + 5'(I_CMD.reg_list[i]);
        end
    end
    assign pick = up_ff ? lo_idx : hi_idx; // RULE1 RULE2
    assign span = {25'h0, cnt, 2'h0} - mle_pkg::WORD_STEP;
    assign size_mask = size_ff == mle_pkg::SZ_BYTE ? mle_pkg::MASK_BYTE
                     : (size_ff == mle_pkg::SZ_HALF ? mle_pkg::MASK_HALF : '1); // RULE12

    always_comb begin
        nxt_state = state_ff;
        nxt_list = list_ff;
        nxt_addr = addr_ff;
        nxt_wbv = wbv_ff;
        nxt_base = base_ff;
        nxt_cur = cur_ff;
        nxt_st = st_ff;
        nxt_size = size_ff;
        nxt_up = up_ff;
        nxt_load = load_ff;
        nxt_wb = wb_ff;
        nxt_excl = excl_ff;
        nxt_mon = mon_ff;
        nxt_mon_addr = mon_addr_ff;
        nxt_mon_size = mon_size_ff;
        nxt_bus = bus_ff;
        nxt_wr = '0;
        nxt_br = 1'b0;
        nxt_bra = bra_ff;
        nxt_done = 1'b0;
        // Another master touching the watched location breaks the reservation
        if (I_SNOOP_VALID && I_SNOOP_ADDR == mon_addr_ff) begin
            nxt_mon = 1'b0; // RULE15
        end
        case (state_ff)
            S_IDLE: begin
                if (I_CMD_VALID && rdy_ff) begin
                    nxt_list = I_CMD.reg_list;
                    nxt_base = I_CMD.base_reg;
                    nxt_wb = I_CMD.writeback;
                    nxt_size = mle_pkg::SZ_WORD;
                    nxt_excl = 1'b0;
                    nxt_st = I_CMD.status_reg;
                    nxt_cur = I_CMD.xfer_reg;
                    nxt_addr = I_BASE_DATA;
                    nxt_state = S_REQ;
                    case (I_CMD.op)
                        // RULE3 RULE4: plain forms and these aliases are increment-after
                        mle_pkg::OP_MULTI_LOAD, mle_pkg::OP_LOAD_INCR_AFTER,
                        mle_pkg::OP_LOAD_FULL_DESC_ALIAS: begin
                            nxt_up = 1'b1;
                            nxt_load = 1'b1;
                        end
                        mle_pkg::OP_LOAD_DECR_BEFORE, mle_pkg::OP_LOAD_EMPTY_ASC_ALIAS: begin
                            nxt_up = 1'b0; // RULE4
                            nxt_load = 1'b1;
                        end
                        mle_pkg::OP_MULTI_STORE, mle_pkg::OP_STORE_INCR_AFTER,
                        mle_pkg::OP_STORE_EMPTY_ASC_ALIAS: begin
                            nxt_up = 1'b1; // RULE3 RULE4
                            nxt_load = 1'b0;
                        end
                        mle_pkg::OP_STORE_DECR_BEFORE,
                        mle_pkg::OP_STORE_FULL_DESC_ALIAS: begin
                            nxt_up = 1'b0; // RULE4
                            nxt_load = 1'b0;
                        end
                        mle_pkg::OP_PUSH: begin
                            nxt_up = 1'b0; // RULE9
                            nxt_load = 1'b0;
                            nxt_wb = 1'b1;
                            nxt_base = mle_pkg::SP_IDX;
                        end
                        mle_pkg::OP_POP: begin
                            nxt_up = 1'b1; // RULE9
                            nxt_load = 1'b1;
                            nxt_wb = 1'b1;
                            nxt_base = mle_pkg::SP_IDX;
                        end
                        mle_pkg::OP_EXCL_LOAD: begin
                            nxt_excl = 1'b1;
                            nxt_load = 1'b1;
                            nxt_wb = 1'b0;
                            nxt_size = I_CMD.size; // RULE12
                            nxt_addr = I_BASE_DATA + {22'h0, I_CMD.offset}; // RULE20
                            nxt_mon = 1'b1; // RULE21
                            nxt_mon_addr = I_BASE_DATA + {22'h0, I_CMD.offset};
                            nxt_mon_size = I_CMD.size;
                        end
                        mle_pkg::OP_EXCL_STORE: begin
                            nxt_excl = 1'b1;
                            nxt_load = 1'b0;
                            nxt_wb = 1'b0;
                            nxt_size = I_CMD.size;
                            nxt_addr = I_BASE_DATA + {22'h0, I_CMD.offset}; // RULE20
                            nxt_mon = 1'b0; // RULE21
                            // Mismatch on address or size simply fails
                            if (!(mon_ff && mon_addr_ff == I_BASE_DATA + {22'h0, I_CMD.offset}
                                  && mon_size_ff == I_CMD.size)
                                || (I_SNOOP_VALID && I_SNOOP_ADDR == mon_addr_ff)) begin
                                nxt_wr = '{we: 1'b1, idx: I_CMD.status_reg,
                                           data: {28'h0, mle_pkg::STAT_FAIL}}; // RULE14 RULE16 RULE19
                                nxt_done = 1'b1;
                                nxt_state = S_IDLE;
                            end
                        end
                        mle_pkg::OP_EXCL_CLEAR: begin
                            nxt_mon = 1'b0; // RULE19
                            nxt_done = 1'b1;
                            nxt_state = S_IDLE;
                        end
                        default: nxt_state = S_IDLE;
                    endcase
                    if (I_CMD.op != mle_pkg::OP_EXCL_LOAD && I_CMD.op != mle_pkg::OP_EXCL_STORE
                        && I_CMD.op != mle_pkg::OP_EXCL_CLEAR) begin
                        nxt_wbv = nxt_up ? I_BASE_DATA + span : I_BASE_DATA - span; // RULE1 RULE2
                        if (I_CMD.reg_list == '0) begin
                            nxt_done = 1'b1; // RULE11
                            nxt_state = S_IDLE;
                        end
                    end
                end
            end
            S_REQ: begin
                if (!excl_ff) begin
                    nxt_cur = pick;
                end
                nxt_bus = '{req: 1'b1, write: !load_ff, size: size_ff, addr: addr_ff,
                            wdata: I_RD_DATA};
                nxt_state = S_WAIT;
            end
            S_WAIT: begin
                if (I_BUS_ACK) begin
                    nxt_bus = '0;
                    if (load_ff) begin
                        nxt_wr = '{we: 1'b1, idx: cur_ff, data: I_BUS_RDATA & size_mask}; // RULE12
                        if (cur_ff == mle_pkg::PC_IDX && !excl_ff) begin
                            nxt_wr.we = 1'b0;
                            nxt_br = 1'b1;
                            nxt_bra = I_BUS_RDATA & mle_pkg::ALIGN_HALF; // RULE6 RULE11
                        end
                    end
                    if (excl_ff) begin
                        if (!load_ff) begin
                            nxt_wr = '{we: 1'b1, idx: st_ff, data: {28'h0, mle_pkg::STAT_OK}}; // RULE14
                        end
                        nxt_done = 1'b1;
                        nxt_state = S_IDLE;
                    end else begin
                        nxt_list[cur_ff] = 1'b0;
                        nxt_addr = up_ff ? addr_ff + mle_pkg::WORD_STEP
                                         : addr_ff - mle_pkg::WORD_STEP; // RULE1 RULE2
                        if (list_ff == (16'h1 << cur_ff)) begin
                            nxt_state = wb_ff ? S_WB : S_IDLE;
                            nxt_done = !wb_ff;
                        end else begin
                            nxt_state = S_REQ;
                        end
                    end
                end
            end
            S_WB: begin
                nxt_wr = '{we: 1'b1, idx: base_ff, data: wbv_ff}; // RULE1 RULE2 RULE9
                nxt_done = 1'b1;
                nxt_state = S_IDLE;
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            state_ff <= S_IDLE;
            list_ff <= '0;
            addr_ff <= '0;
            wbv_ff <= '0;
            base_ff <= '0;
            cur_ff <= '0;
            st_ff <= '0;
            size_ff <= '0;
            up_ff <= 1'b0;
            load_ff <= 1'b0;
            wb_ff <= 1'b0;
            excl_ff <= 1'b0;
            mon_ff <= 1'b0;
            mon_addr_ff <= '0;
            mon_size_ff <= '0;
            bus_ff <= '0;
            wr_ff <= '0;
            br_ff <= 1'b0;
            bra_ff <= '0;
            done_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            list_ff <= nxt_list;
            addr_ff <= nxt_addr;
            wbv_ff <= nxt_wbv;
            base_ff <= nxt_base;
            cur_ff <= nxt_cur;
            st_ff <= nxt_st;
            size_ff <= nxt_size;
            up_ff <= nxt_up;
            load_ff <= nxt_load;
            wb_ff <= nxt_wb;
            excl_ff <= nxt_excl;
            mon_ff <= nxt_mon;
            mon_addr_ff <= nxt_mon_addr;
            mon_size_ff <= nxt_mon_size;
            bus_ff <= nxt_bus;
            wr_ff <= nxt_wr;
            br_ff <= nxt_br;
            bra_ff <= nxt_bra;
            done_ff <= nxt_done;
        end
    end

    // Read index is taken one cycle ahead from the next list, so the port is a flop
    logic [3:0] rd_ff, nxt_rd, nxt_lo, nxt_hi;
    always_comb begin
        nxt_lo = '0;
        nxt_hi = '0;
        for (int i = 0; i < mle_pkg::NREG; i++) begin
            if (nxt_list[mle_pkg::NREG - 1 - i]) begin
                nxt_lo = 4'(mle_pkg::NREG - 1 - i);
            end
            if (nxt_list[i]) begin
                nxt_hi = 4'(i);
            end
        end
    end
    assign nxt_rd = nxt_excl ? nxt_cur : (nxt_up ? nxt_lo : nxt_hi);
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rd_ff <= '0;
        end else begin
            rd_ff <= nxt_rd;
        end
    end
    always_ff @(posedge I_SYS_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            rdy_ff <= 1'b0;
        end else begin
            rdy_ff <= (nxt_state == S_IDLE);
        end
    end
    assign O_CMD_READY = rdy_ff;
    assign O_RD_IDX = rd_ff;
    assign O_BUS = bus_ff;
    assign O_REG_WR = wr_ff;
    assign O_BRANCH = br_ff;
    assign O_BRANCH_ADDR = bra_ff;
    assign O_DONE = done_ff;

    property p_branch_aligned;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        O_BRANCH |-> O_BRANCH_ADDR == ($past(I_BUS_RDATA) & mle_pkg::ALIGN_HALF) && !O_REG_WR.we;
    endproperty
    a_branch_aligned: assert property (p_branch_aligned) else $error("bad branch target"); // RULE6
    property p_wb_last;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        state_ff == S_WB |=> O_REG_WR.we && O_REG_WR.idx == $past(base_ff) && O_DONE;
    endproperty
    a_wb_last: assert property (p_wb_last) else $error("writeback missing"); // RULE1
    property p_step_up;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        state_ff == S_WAIT && I_BUS_ACK && !excl_ff && up_ff
            |=> addr_ff == $past(addr_ff) + mle_pkg::WORD_STEP;
    endproperty
    a_step_up: assert property (p_step_up) else $error("increment step wrong"); // RULE1
    property p_step_down;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        state_ff == S_WAIT && I_BUS_ACK && !excl_ff && !up_ff
            |=> addr_ff == $past(addr_ff) - mle_pkg::WORD_STEP;
    endproperty
    a_step_down: assert property (p_step_down) else $error("decrement step wrong"); // RULE2
    property p_clear_fails;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        !mon_ff && state_ff == S_IDLE && O_CMD_READY && I_CMD_VALID
            && I_CMD.op == mle_pkg::OP_EXCL_STORE
            |=> O_REG_WR.we && O_REG_WR.data == 32'h1 && !O_BUS.req;
    endproperty
    a_clear_fails: assert property (p_clear_fails) else $error("store not failed"); // RULE19
    property p_excl_ok;
        @(posedge I_SYS_CLK) disable iff (!I_RESETN)
        state_ff == S_WAIT && I_BUS_ACK && excl_ff && !load_ff
            |=> O_REG_WR.we && O_REG_WR.idx == $past(st_ff) && O_REG_WR.data == 32'h0 && O_DONE;
    endproperty
    a_excl_ok: assert property (p_excl_ok) else $error("store status wrong"); // RULE14
    c_excl: cover property (@(posedge I_SYS_CLK) O_REG_WR.we && excl_ff && O_REG_WR.data == 32'h0);
    c_branch: cover property (@(posedge I_SYS_CLK) O_BRANCH);
    c_wb: cover property (@(posedge I_SYS_CLK) state_ff == S_WB);
endmodule // mle_unit
`default_nettype wire

// *** src/mle_pkg.sv ***
// Purpose: Constants and types for the multiple and exclusive load/store unit.
// Assumes: One 32-bit word bus, one access in flight at a time.
// Notes: Operations are decoded upstream into the command struct below.
// Summary of operation
// RULE1: Increment-after walks upward, lowest register first
// RULE2: Decrement-before walks downward, highest register first
// RULE3: No addressing mode means increment-after
// RULE4: Aliases map to increment-after or decrement-before
// RULE5: Software avoids illegal base and list registers
// RULE6: Loaded counter bit 0 set; branch halfword-aligned
// RULE7: Counter-writing conditional load ends conditional block
// RULE8: Condition flags are never modified
// RULE9: Push/pop are stack-based multiples with writeback
// RULE10: Software keeps stack pointer out of lists
// RULE11: Lists non-empty; pop to counter branches aligned
// RULE12: Exclusive loads read word, byte or halfword
// RULE13: Exclusive store matches last exclusive load
// RULE14: Status 0 when stored, 1 when not
// RULE15: Success only if location untouched since load
// RULE16: Mismatched exclusive store address gives undefined outcome
// RULE17: Word exclusive offset multiple of four, 0-1020
// RULE18: Exclusive operands avoid counter and stack pointer
// RULE19: After exclusive clear next exclusive store fails
// RULE20: Omitted offset uses base register unchanged
// RULE21: Local monitor holds address and size
package mle_pkg;
    localparam int NREG = 16;
    localparam int AW = 32;
    localparam logic [3:0] SP_IDX = 4'hd;
    localparam logic [3:0] PC_IDX = 4'hf;
    localparam logic [31:0] WORD_STEP = 32'h0000_0004;
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_HALF = 2'h1;
    localparam logic [1:0] SZ_WORD = 2'h2;
    localparam logic [31:0] ALIGN_HALF = 32'hffff_fffe;
    localparam logic [31:0] MASK_BYTE = 32'h0000_00ff;
    localparam logic [31:0] MASK_HALF = 32'h0000_ffff;
    localparam logic [3:0] STAT_OK = 4'h0;
    localparam logic [3:0] STAT_FAIL = 4'h1;
    typedef enum logic [3:0] {
        OP_MULTI_LOAD, OP_LOAD_INCR_AFTER, OP_LOAD_DECR_BEFORE, OP_LOAD_FULL_DESC_ALIAS,
        OP_LOAD_EMPTY_ASC_ALIAS, OP_MULTI_STORE, OP_STORE_INCR_AFTER, OP_STORE_DECR_BEFORE,
        OP_STORE_EMPTY_ASC_ALIAS, OP_STORE_FULL_DESC_ALIAS, OP_PUSH, OP_POP,
        OP_EXCL_LOAD, OP_EXCL_STORE, OP_EXCL_CLEAR
    } mle_op_type;
    typedef struct packed {
        mle_op_type op;
        logic [1:0] size;
        logic writeback;
        logic [3:0] base_reg;
        logic [3:0] xfer_reg;
        logic [3:0] status_reg;
        logic [15:0] reg_list;
        logic [9:0] offset;
    } mle_cmd_type;
    typedef struct packed {
        logic req;
        logic write;
        logic [1:0] size;
        logic [31:0] addr;
        logic [31:0] wdata;
    } mle_bus_type;
    typedef struct packed {
        logic we;
        logic [3:0] idx;
        logic [31:0] data;
    } mle_wr_type;
endpackage

// *** dv/mle_mem_model.sv ***
// Purpose: Behavioural memory answering the unit's bus requests.
// Assumes: Address bits 7:2 pick one of 64 words; higher bits alias.
// Notes: Read data turns to its inverse once the answer is gone.
`timescale 1ns/1ps
`default_nettype none
module mle_mem_model (
    input wire logic i_clk,                  // Clock
    input wire mle_pkg::mle_bus_type i_bus,  // Request from the unit
    input wire logic [3:0] i_lat,            // Request cycles before the answer
    output logic o_ack,                      // Answer pulse
    output logic [31:0] o_rdata              // Read data with the answer
);
    logic [31:0] mem [64];
    logic idle;
    int cnt;
    initial begin
        o_ack = 1'b0;
        o_rdata = 32'h0;
        idle = 1'b0;
        cnt = 0;
        for (int i = 0; i < 64; i++) mem[i] = 32'h1234_0000 ^ 32'(i * 4);
    end
    // One quiet cycle after each answer, so a lingering request is not answered twice
    always @(negedge i_clk) begin
        if (o_ack) begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            idle <= 1'b1;
        end else if (idle) begin
            idle <= 1'b0;
        end else if (i_bus.req) begin
            cnt = cnt + 1;
            if (cnt >= 32'(i_lat)) begin
                cnt = 0;
                o_ack <= 1'b1;
                if (i_bus.write) mem[i_bus.addr[7:2]] <= i_bus.wdata;
                else o_rdata <= mem[i_bus.addr[7:2]];
            end
        end
    end
    task automatic poke(input logic [7:0] a, input logic [31:0] d);
        mem[a[7:2]] = d;
    endtask
endmodule // mle_mem_model
`default_nettype wire

// *** dv/multi_and_exclusive_load_store_test.sv ***
// Purpose: Self-checking bench for the multiple and exclusive load/store unit.
// Assumes: Register file value of register r is c0de_000r.
// Notes: Bus and register-write traffic is logged per command, then judged.
`timescale 1ns/1ps
`default_nettype none
module multi_and_exclusive_load_store_test;
    logic clk, rstn, cmd_valid, snoop_valid, ack, cmd_ready, branch, done;
    mle_pkg::mle_cmd_type cmd;
    mle_pkg::mle_bus_type bus;
    mle_pkg::mle_wr_type wr;
    logic [31:0] base, rdata, snoop_addr, br_addr;
    logic [3:0] rd_idx, lat;
    logic [31:0] ba_q[$], bd_q[$], ri_q[$], rv_q[$], br_q[$];
    logic bw_q[$];
    logic [1:0] bs_q[$];
    int n_mismatch, compares, cycles;
    function automatic logic [31:0] regval(input logic [3:0] r);
        return 32'hc0de_0000 | {28'h0, r};
    endfunction
    function automatic logic [31:0] memval(input logic [31:0] a);
        return 32'h1234_0000 ^ {24'h0, a[7:2], 2'b00};
    endfunction
    mle_unit dut (.I_SYS_CLK(clk), .I_RESETN(rstn), .I_CMD_VALID(cmd_valid), .I_CMD(cmd),
        .O_CMD_READY(cmd_ready), .O_RD_IDX(rd_idx), .I_RD_DATA(regval(rd_idx)),
        .I_BASE_DATA(base), .O_BUS(bus), .I_BUS_ACK(ack), .I_BUS_RDATA(rdata),
        .I_SNOOP_VALID(snoop_valid), .I_SNOOP_ADDR(snoop_addr), .O_REG_WR(wr),
        .O_BRANCH(branch), .O_BRANCH_ADDR(br_addr), .O_DONE(done));
    mle_mem_model mem_i (.i_clk(clk), .i_bus(bus), .i_lat(lat), .o_ack(ack), .o_rdata(rdata));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (bus.req && ack) begin
            ba_q.push_back(bus.addr);
            bw_q.push_back(bus.write);
            bs_q.push_back(bus.size);
            bd_q.push_back(bus.write ? bus.wdata : rdata);
        end
        if (wr.we) begin
            ri_q.push_back({28'h0, wr.idx});
            rv_q.push_back(wr.data);
        end
        if (branch) br_q.push_back(br_addr);
        // Whole run needs a few hundred cycles
        if (cycles == 20000) begin
            n_mismatch++;
            summarize();
        end
    end
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic run(input mle_pkg::mle_cmd_type c, input logic [31:0] b);
        int k;
        ba_q.delete();
        bd_q.delete();
        bw_q.delete();
        bs_q.delete();
        ri_q.delete();
        rv_q.delete();
        br_q.delete();
        @(negedge clk);
        cmd = c;
        base = b;
        cmd_valid = 1'b1;
        do @(posedge clk); while (cmd_ready !== 1'b1);
        @(negedge clk);
        cmd_valid = 1'b0;
        k = 0;
        while (done !== 1'b1 && k < 400) begin
            @(negedge clk);
            k++;
        end
        chk("done", 32'h1, {31'h0, done});
        repeat (2) @(negedge clk);
    endtask
    task automatic multi(input int i);
        mle_pkg::mle_cmd_type c;
        logic ld, up, wb;
        logic [3:0] r;
        logic [31:0] b, a;
        int k;
        ld = i < 5 || i == 11;
        up = !(i inside {2, 4, 7, 9, 10});
        wb = i % 4 != 0 && i < 10;
        b = ld ? (up ? 32'h40 : 32'h7c) : (up ? 32'h90 : 32'hf0);
        c = '0;
        c.op = mle_pkg::mle_op_type'(i);
        c.writeback = wb;
        c.reg_list = 16'h0205;
        c.base_reg = i >= 10 ? mle_pkg::SP_IDX : 4'h3;
        lat = 4'(1 + i % 3);
        run(c, b);
        k = 0;
        chk("accesses", 32'h3, 32'(ba_q.size()));
        for (int j = 0; j < 16; j++) begin
            r = up ? 4'(j) : 4'(15 - j);
            a = up ? b + 32'(4 * k) : b - 32'(4 * k);
            if (c.reg_list[r] && k < ba_q.size()) begin
                chk("addr", a, ba_q[k]);
                chk("write", {31'h0, !ld}, {31'h0, bw_q[k]});
                chk("data", ld ? memval(a) : regval(r), bd_q[k]);
                if (ld && k < ri_q.size()) chk("dest", {28'h0, r}, ri_q[k]);
                if (ld && k < rv_q.size()) chk("value", memval(a), rv_q[k]);
                k++;
            end
        end
        wb = wb || i >= 10;
        chk("reg writes", (ld ? 32'h3 : 32'h0) + {31'h0, wb}, 32'(ri_q.size()));
        if (wb && ri_q.size() > 0) begin
            chk("wb reg", {28'h0, c.base_reg}, ri_q[$]);
            chk("wb value", up ? b + 32'h8 : b - 32'h8, rv_q[$]);
        end
    endtask
    task automatic pc_pop();
        mle_pkg::mle_cmd_type c;
        c = '0;
        c.op = mle_pkg::OP_POP;
        c.base_reg = mle_pkg::SP_IDX;
        c.reg_list = 16'h8002;
        mem_i.poke(8'h24, 32'h0000_1235);
        run(c, 32'h20);
        chk("branches", 32'h1, 32'(br_q.size()));
        if (br_q.size() > 0) chk("target", 32'h0000_1234, br_q[0]);
        chk("reg writes", 32'h2, 32'(ri_q.size()));
        if (ri_q.size() == 2) begin
            chk("dest", 32'h1, ri_q[0]);
            chk("value", memval(32'h20), rv_q[0]);
            chk("wb value", 32'h24, rv_q[1]);
        end
    endtask
    task automatic excl(input mle_pkg::mle_op_type op, input logic [1:0] sz, input logic ok);
        mle_pkg::mle_cmd_type c;
        logic [31:0] a, m;
        logic st;
        st = op == mle_pkg::OP_EXCL_STORE;
        c = '0;
        c.op = op;
        c.size = sz;
        c.offset = sz == mle_pkg::SZ_WORD ? 10'h3fc : 10'h0;
        c.base_reg = 4'h6;
        c.xfer_reg = 4'h4;
        c.status_reg = 4'h5;
        a = 32'h100 + {22'h0, c.offset};
        m = sz == mle_pkg::SZ_BYTE ? mle_pkg::MASK_BYTE
            : (sz == mle_pkg::SZ_HALF ? mle_pkg::MASK_HALF : 32'hffff_ffff);
        run(c, 32'h100);
        chk("accesses", {31'h0, ok}, 32'(ba_q.size()));
        if (ba_q.size() > 0) begin
            chk("addr", a, ba_q[0]);
            chk("size", {30'h0, sz}, {30'h0, bs_q[0]});
            chk("write", {31'h0, st}, {31'h0, bw_q[0]});
            if (st) chk("wdata", regval(4'h4), bd_q[0]);
        end
        chk("reg writes", {31'h0, op != mle_pkg::OP_EXCL_CLEAR}, 32'(ri_q.size()));
        if (ri_q.size() > 0 && !st) begin
            chk("dest", 32'h4, ri_q[0]);
            if (ba_q.size() > 0) chk("value", bd_q[0] & m, rv_q[0]);
        end
        if (ri_q.size() > 0 && st) begin
            chk("status reg", 32'h5, ri_q[0]);
            chk("status", {28'h0, ok ? mle_pkg::STAT_OK : mle_pkg::STAT_FAIL}, rv_q[0]);
        end
    endtask
    task automatic snoop(input logic [31:0] a);
        @(negedge clk);
        snoop_valid = 1'b1;
        snoop_addr = a;
        @(negedge clk);
        snoop_valid = 1'b0;
    endtask
    initial begin
        rstn = 1'b0;
        cmd_valid = 1'b0;
        cmd = '0;
        base = 32'h0;
        snoop_valid = 1'b0;
        snoop_addr = 32'h0;
        lat = 4'h1;
        n_mismatch = 0;
        compares = 0;
        cycles = 0;
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        repeat (2) @(negedge clk);
        for (int i = 0; i < 12; i++) multi(i);
        pc_pop();
        lat = 4'h2;
        for (int s = 0; s < 3; s++) begin
            excl(mle_pkg::OP_EXCL_LOAD, 2'(s), 1'b1);
            excl(mle_pkg::OP_EXCL_STORE, 2'(s), 1'b1);
            excl(mle_pkg::OP_EXCL_STORE, 2'(s), 1'b0);
        end
        excl(mle_pkg::OP_EXCL_LOAD, mle_pkg::SZ_WORD, 1'b1);
        excl(mle_pkg::OP_EXCL_CLEAR, mle_pkg::SZ_WORD, 1'b0);
        excl(mle_pkg::OP_EXCL_STORE, mle_pkg::SZ_WORD, 1'b0);
        excl(mle_pkg::OP_EXCL_LOAD, mle_pkg::SZ_WORD, 1'b1);
        snoop(32'h0000_04fc);
        excl(mle_pkg::OP_EXCL_STORE, mle_pkg::SZ_WORD, 1'b0);
        excl(mle_pkg::OP_EXCL_LOAD, mle_pkg::SZ_WORD, 1'b1);
        snoop(32'h0000_04f8);
        excl(mle_pkg::OP_EXCL_STORE, mle_pkg::SZ_WORD, 1'b1);
        summarize();
    end
endmodule // multi_and_exclusive_load_store_test
`default_nettype wire
